// ===== rtl/sqc_pkg.sv
// package: register map, field layout, reset values and types of the sequence controller
// What this block does
// - writing any control register aborts, only control register 5 starts a sequence
// - length field bits 6:3, zero means sixteen
// - reset length is four conversions
// - non fifo: result n to register n
// - fifo: slot counter runs across sequences
// - fifo slot counter wraps after last register
// - slot counter readable in status register
// - abort or new start clears slot counter
// - freeze field: continue, finish then halt, immediate
package sqc_pkg;
  // byte addresses of the registers
  localparam logic [7:0] SQC_CTL0_OFS = 8'h00; // converter control register 0
  localparam logic [7:0] SQC_CTL1_OFS = 8'h04; // converter control register 1
  localparam logic [7:0] SQC_CTL2_OFS = 8'h08; // converter control register 2
  localparam logic [7:0] SQC_SEQ_OFS = 8'h0C; // sequence_control_reg, printed index 3
  localparam logic [7:0] SQC_CTL4_OFS = 8'h10; // converter control register 4
  localparam logic [7:0] SQC_CTL5_OFS = 8'h14; // control register 5, starts a sequence
  localparam logic [7:0] SQC_STAT_OFS = 8'h18; // converter_status_reg_zero
  // sequence_control_reg field positions
  localparam int SQC_LEN_LSB = 3; // seq_len_weight1 .. seq_len_weight8 at 6:3
  localparam int SQC_FIFO_BIT = 2; // fifo mode
  localparam int SQC_FRZ_LSB = 0; // breakpoint_response at 1:0
  localparam logic [7:0] SQC_SEQ_RST = 8'h20; // seq_len_weight4 set
  // status register fields
  localparam int SQC_STAT_CC_LSB = 0; // result_slot_counter at 3:0
  localparam int SQC_STAT_BUSY_BIT = 4; // sequence active
  localparam int SQC_STAT_FRZ_BIT = 5; // frozen
  localparam int SQC_STAT_SCF_BIT = 7; // sequence complete
  // control register 5 fields
  localparam int SQC_SCAN_BIT = 5; // continuous scan
  // conversion length in clock cycles (stand-in for the analog core)
  localparam logic [3:0] SQC_CONV_CYC = 4'hB;
  localparam logic [1:0] SQC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SQC_RESP_SLVERR = 2'h2;
  // freeze codes
  typedef enum logic [1:0] {
    SQC_FRZ_CONT = 2'b00,
    SQC_FRZ_RSVD = 2'b01,
    SQC_FRZ_FINISH = 2'b10,
    SQC_FRZ_NOW = 2'b11
  } sqc_frz_t;
  // result written into the result file
  typedef struct packed {
    logic valid; // one-cycle write strobe
    logic [3:0] slot; // result register index
  } sqc_result_t;
endpackage : sqc_pkg

// ===== rtl/sqc_conv.sv
// conversion timer: counts one conversion, holds its state while frozen
`timescale 1ns/1ps
`default_nettype none
module sqc_conv (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic abort,
  input wire logic hold,
  output logic busy,
  output logic done
);
  logic [3:0] cnt_q; // cycles left in current conversion
  // a held count keeps its saved state so freeze resumes, not restarts
  always_ff @(posedge aclk) begin
    if (!aresetn || abort) begin
      cnt_q <= 4'h0;
    end else if (start) begin
      cnt_q <= sqc_pkg::SQC_CONV_CYC;
    end else if (cnt_q != 4'h0 && !hold) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign busy = (cnt_q != 4'h0);
  assign done = (cnt_q == 4'h1) && !hold && !abort;
endmodule : sqc_conv
`default_nettype wire

// ===== rtl/sqc_top.sv
// sequence length, result placement and freeze control with an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module sqc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic freeze_req,
  output logic result_we,
  output logic [3:0] result_slot
);
  ////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] ctl_q [0:5]; // control registers 0..5, 3 is the sequence one
  logic [7:0] stat_q; // status flags
  logic [3:0] cc_q; // result_slot_counter
  logic [4:0] done_q; // conversions done in this sequence
  logic seq_act_q; // sequence in progress
  logic frz_q; // currently frozen
  logic aw_hold_q; // address captured
  logic w_hold_q; // data captured
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_wr; // write commits this cycle
  logic wr_ctl; // write hits a control register
  logic wr_go; // write to register 5 starts
  logic conv_start;
  logic conv_busy;
  logic conv_done;
  logic hold;
  logic [4:0] seq_len;
  sqc_pkg::sqc_frz_t frz_mode;
  sqc_pkg::sqc_result_t res_q;

  // map a byte address to a control register index, 7 when none
  function automatic logic [2:0] ctl_index(input logic [7:0] a);
    case (a)
      sqc_pkg::SQC_CTL0_OFS: ctl_index = 3'd0;
      sqc_pkg::SQC_CTL1_OFS: ctl_index = 3'd1;
      sqc_pkg::SQC_CTL2_OFS: ctl_index = 3'd2;
      sqc_pkg::SQC_SEQ_OFS: ctl_index = 3'd3;
      sqc_pkg::SQC_CTL4_OFS: ctl_index = 3'd4;
      sqc_pkg::SQC_CTL5_OFS: ctl_index = 3'd5;
      default: ctl_index = 3'd7;
    endcase
  endfunction : ctl_index

  ////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_awvalid && s_awready) begin
      aw_hold_q <= 1'b1;
      awaddr_q <= s_awaddr;
    end else if (do_wr) begin
      aw_hold_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_wvalid && s_wready) begin
      w_hold_q <= 1'b1;
      wdata_q <= s_wdata;
      wstrb_q <= s_wstrb;
    end else if (do_wr) begin
      w_hold_q <= 1'b0;
    end
  end
  // ready only while nothing is held and no answer is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
    end else begin
      s_awready <= !aw_hold_q && !(s_awvalid && s_awready) && !s_bvalid && !do_wr;
      s_wready <= !w_hold_q && !(s_wvalid && s_wready) && !s_bvalid && !do_wr;
    end
  end
  assign do_wr = aw_hold_q && w_hold_q && !s_bvalid;
  assign wr_ctl = do_wr && (ctl_index(awaddr_q) != 3'd7) && wstrb_q[0];
  assign wr_go = wr_ctl && (ctl_index(awaddr_q) == 3'd5);
  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= sqc_pkg::SQC_RESP_OKAY;
    end else if (do_wr) begin
      s_bvalid <= 1'b1;
      s_bresp <= (ctl_index(awaddr_q) == 3'd7 && awaddr_q != sqc_pkg::SQC_STAT_OFS) ?
                 sqc_pkg::SQC_RESP_SLVERR : sqc_pkg::SQC_RESP_OKAY;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end
  // control registers, only lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 6; i++) begin
        ctl_q[i] <= (i == 3) ? sqc_pkg::SQC_SEQ_RST : 8'h00;
      end
    end else if (wr_ctl) begin
      ctl_q[ctl_index(awaddr_q)] <= wdata_q[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= sqc_pkg::SQC_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rresp <= sqc_pkg::SQC_RESP_OKAY;
      if (s_araddr == sqc_pkg::SQC_STAT_OFS) begin
        s_rdata <= {24'h000000, stat_q[7:4], cc_q};
      end else if (ctl_index(s_araddr) != 3'd7) begin
        s_rdata <= {24'h000000, ctl_q[ctl_index(s_araddr)]};
      end else begin
        s_rdata <= 32'h0000_0000;
        s_rresp <= sqc_pkg::SQC_RESP_SLVERR;
      end
    end else if (s_rvalid) begin
      if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end else begin
      s_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence control
  assign seq_len = {(ctl_q[3][6:3] == 4'h0), ctl_q[3][6:3]};
  assign frz_mode = sqc_pkg::sqc_frz_t'(ctl_q[3][1:0]);
  // reserved code behaves as continue; finish mode halts only between conversions
  always_comb begin
    case (frz_mode)
      sqc_pkg::SQC_FRZ_NOW: hold = freeze_req;
      sqc_pkg::SQC_FRZ_FINISH: hold = freeze_req && !conv_busy;
      default: hold = 1'b0;
    endcase
  end
  assign conv_start = seq_act_q && !conv_busy && !hold && !wr_ctl;

  sqc_conv u_conv (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(conv_start),
    .abort(wr_ctl),
    .hold(hold),
    .busy(conv_busy),
    .done(conv_done)
  );

  // sequence state, abort on any control write, start only from register 5
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_act_q <= 1'b0;
      done_q <= 5'h00;
    end else if (wr_ctl) begin
      seq_act_q <= wr_go;
      done_q <= 5'h00;
    end else if (conv_done) begin
      if (done_q + 5'h01 == seq_len) begin
        done_q <= 5'h00;
        seq_act_q <= ctl_q[5][sqc_pkg::SQC_SCAN_BIT];
      end else begin
        done_q <= done_q + 5'h01;
      end
    end
  end
  // slot counter; a control write clears it even in fifo mode
  always_ff @(posedge aclk) begin
    if (!aresetn || wr_ctl) begin
      cc_q <= 4'h0;
    end else if (conv_done) begin
      if (!ctl_q[3][sqc_pkg::SQC_FIFO_BIT] && done_q + 5'h01 == seq_len) begin
        cc_q <= 4'h0;
      end else begin
        cc_q <= cc_q + 4'h1;
      end
    end
  end
  // result strobe into the result file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_q <= '0;
    end else begin
      res_q.valid <= conv_done;
      res_q.slot <= cc_q;
    end
  end
  assign result_we = res_q.valid;
  assign result_slot = res_q.slot;
  // status flags; a control write masks conv_done, so clear wins over completion set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 8'h00;
      frz_q <= 1'b0;
    end else begin
      frz_q <= hold;
      stat_q[sqc_pkg::SQC_STAT_BUSY_BIT] <= seq_act_q;
      stat_q[sqc_pkg::SQC_STAT_FRZ_BIT] <= frz_q;
      if (conv_done && done_q + 5'h01 == seq_len) begin
        stat_q[sqc_pkg::SQC_STAT_SCF_BIT] <= 1'b1;
      end else if (wr_ctl) begin
        stat_q[sqc_pkg::SQC_STAT_SCF_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_abort_nostart: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctl && !wr_go |=> !seq_act_q) else $error("control write did not abort");
  chk_slot_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctl |=> cc_q == 4'h0) else $error("slot counter not cleared");
  chk_fifo_step: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done && !wr_ctl && ctl_q[3][2] |=> cc_q == $past(cc_q) + 4'h1)
    else $error("fifo slot did not advance");
  chk_fifo_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done && !wr_ctl && ctl_q[3][2] && cc_q == 4'hF |=> cc_q == 4'h0)
    else $error("fifo slot did not wrap");
  chk_seq_end: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done && !wr_ctl && !ctl_q[3][2] && done_q + 5'h01 == seq_len |=> cc_q == 4'h0)
    else $error("fixed mode slot not reset");
  chk_len_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_act_q |-> done_q < seq_len) else $error("sequence overran length");
  chk_frz_now: assert property (@(posedge aclk) disable iff (!aresetn)
    freeze_req && frz_mode == sqc_pkg::SQC_FRZ_NOW |-> !conv_done)
    else $error("conversion finished while frozen");
  chk_frz_cont: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctl_q[3][1] |-> !hold) else $error("continue code halted");
  chk_stat_cc: assert property (@(posedge aclk) disable iff (!aresetn)
    s_arvalid && s_arready && s_araddr == sqc_pkg::SQC_STAT_OFS
    |=> s_rdata[3:0] == $past(cc_q)) else $error("status slot wrong");
endmodule : sqc_top
`default_nettype wire

// ===== test/tb_top.sv
// testbench: register access, sequence length, result placement and freeze response
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk = 1'h0; // bus clock
  logic aresetn = 1'h0; // sync reset, active low
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic freeze_req = 1'h0; // debug breakpoint request
  logic awready, wready, bvalid, arready, rvalid, result_we;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] result_slot;
  logic [3:0] slots[$]; // slots of results seen
  logic [31:0] rd; // last read data
  logic [1:0] rs; // last response code
  int n_errors = 0;
  int n_checks = 0;
  int i;
  sqc_top dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .freeze_req(freeze_req),
    .result_we(result_we), .result_slot(result_slot));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and result monitor
  initial forever #20 aclk = ~aclk;
  always @(posedge aclk) if (aresetn && result_we === 1'h1) slots.push_back(result_slot);
  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask : chk
  // a wait that ran out ends the run
  task fail_to;
    n_errors++;
    $display("unexpected wait: no answer in time");
    stop_test();
  endtask : fail_to
  // write: address and data offered together, each dropped when taken
  task wr(input logic [7:0] a, input logic [7:0] d);
    int k;
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (k = 0; k < 100 && !(aw_ok && w_ok); k++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'h1) begin
        awvalid <= 1'h0;
        aw_ok = 1'h1;
      end
      if (wvalid && wready === 1'h1) begin
        wvalid <= 1'h0;
        w_ok = 1'h1;
      end
    end
    // address or data never taken counts as a hang
    if (!(aw_ok && w_ok)) fail_to();
    for (k = 0; k < 100 && bvalid !== 1'h1; k++) @(posedge aclk);
    if (k == 100) fail_to();
    rs = bresp;
    bready <= 1'h0;
  endtask : wr
  // read: rready held until the answer is sampled
  task rdr(input logic [7:0] a);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    if (k == 100) fail_to();
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask : rdr
  task idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle
  // wait for n results, then compare slots against j mod m
  task chk_seq(input int n, input int m);
    int j;
    for (j = 0; j < 40 * n && slots.size() < n; j++) @(posedge aclk);
    if (slots.size() < n) fail_to();
    for (j = 0; j < n; j++) chk("result slot", 32'(j % m), {28'h0, slots[j]});
  endtask : chk_seq
  // abort by a control write, then forget stale results
  task abort_clr(input logic [7:0] v);
    wr(sqc_pkg::SQC_SEQ_OFS, v);
    idle(3);
    slots.delete();
  endtask : abort_clr
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rdr(sqc_pkg::SQC_SEQ_OFS);
    chk("sequence reg reset", 32'h20, rd);
    rdr(8'h40);
    chk("unmapped resp", {30'h0, sqc_pkg::SQC_RESP_SLVERR}, {30'h0, rs});
    // single sequence of two, then silence
    abort_clr(8'h10);
    chk("write resp", {30'h0, sqc_pkg::SQC_RESP_OKAY}, {30'h0, rs});
    wr(sqc_pkg::SQC_CTL5_OFS, 8'h00);
    chk_seq(2, 2);
    idle(60);
    chk("results of two", 32'h2, 32'(slots.size()));
    // length code zero gives sixteen
    abort_clr(8'h00);
    wr(sqc_pkg::SQC_CTL5_OFS, 8'h00);
    chk_seq(16, 16);
    idle(60);
    chk("results of sixteen", 32'h10, 32'(slots.size()));
    // scan without fifo restarts at slot zero each sequence
    abort_clr(8'h18);
    wr(sqc_pkg::SQC_CTL5_OFS, 8'h20);
    chk_seq(6, 3);
    // scan with fifo runs across sequences and wraps
    abort_clr(8'h1C);
    wr(sqc_pkg::SQC_CTL5_OFS, 8'h20);
    chk_seq(18, 16);
    // control write stops the scan and clears the counter
    abort_clr(8'h1C);
    idle(40);
    chk("results after abort", 32'h0, 32'(slots.size()));
    rdr(sqc_pkg::SQC_STAT_OFS);
    chk("slot counter after abort", 32'h0, {28'h0, rd[3:0]});
    // fifo single sequence leaves counter after last result
    wr(sqc_pkg::SQC_CTL5_OFS, 8'h00);
    chk_seq(3, 16);
    idle(60);
    rdr(sqc_pkg::SQC_STAT_OFS);
    chk("slot counter", 32'h3, {28'h0, rd[3:0]});
    // every freeze code while scanning, then release
    for (i = 0; i < 4; i++) begin
      abort_clr({6'h02, i[1:0]});
      wr(sqc_pkg::SQC_CTL5_OFS, 8'h20);
      chk_seq(1, 1);
      freeze_req <= 1'h1;
      slots.delete();
      idle(40);
      if (i == 3) chk("results frozen now", 32'h0, 32'(slots.size()));
      else if (i == 2) chk("results finish first", 32'h1, 32'(slots.size() <= 1));
      else chk("results continuing", 32'h1, 32'(slots.size() >= 2));
      rdr(sqc_pkg::SQC_STAT_OFS);
      chk("frozen flag", 32'(i >> 1), {31'h0, rd[5]});
      freeze_req <= 1'h0;
      slots.delete();
      idle(i == 3 ? 14 : 30);
      chk("results after release", 32'h1, 32'(slots.size() >= 1));
    end
    abort_clr(8'h20);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
